// ---- rtl/cce_defines.vh ----
`ifndef CCE_DEFINES_VH
`define CCE_DEFINES_VH
// =====================================================
// register map (byte addresses)
`define CCE_ADDR_CTRL      8'h00
`define CCE_ADDR_INSTR     8'h04
`define CCE_ADDR_FADDR     8'h08
`define CCE_ADDR_FRDATA    8'h0c
`define CCE_ADDR_ACC       8'h10
`define CCE_ADDR_STATUS    8'h14
`define CCE_ADDR_FWDATA    8'h18
`define CCE_ADDR_WDOG      8'h1c
// =====================================================
// field positions
`define CCE_CTRL_GO        0
`define CCE_ST_BUSY        0
`define CCE_ST_ZERO        1
`define CCE_ST_TIMEOUT     2
`define CCE_ST_POWERDOWN   3
`define CCE_ST_FWRITE      4
`define CCE_ST_ILLEGAL     5
`define CCE_DEST_BIT       7
// =====================================================
// opcodes
`define CCE_OP_ACC_CLEAR   7'h02
`define CCE_OP_WDOG        14'h0064
`define CCE_OP_COMPL       6'h09
// =====================================================
// reset values and timing
`define CCE_RST_ACC        8'h00
`define CCE_RST_WDOG_LIMIT 8'hff
`define CCE_PHASES         4
`define CCE_AXI_SLVERR     2'h2
`define CCE_AXI_OKAY       2'h0
`endif

// ---- rtl/cce_exec_unit.v ----
`timescale 1ns/1ps
`include "cce_defines.vh"
// =====================================================
// decode and execute, one instruction cycle of four phases
module cce_exec_unit (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire        start,
  input  wire [13:0] instr,
  input  wire [7:0]  file_rdata,
  output reg         busy_q,
  output reg  [7:0]  acc_q,
  output reg         zero_q,
  output reg         timeout_flag_q,
  output reg         powerdown_flag_q,
  output reg         file_we_q,
  output reg  [6:0]  file_addr_q,
  output reg  [7:0]  file_wdata_q,
  output reg         wdog_clear_q,
  output reg         illegal_q
);
  reg  [1:0]  phase_q;
  reg  [13:0] ir_q;
  reg  [7:0]  result_q;
  wire        is_acc_clear = (ir_q[13:7] == `CCE_OP_ACC_CLEAR);
  wire        is_wdog      = (ir_q == `CCE_OP_WDOG);
  wire        is_compl     = (ir_q[13:8] == `CCE_OP_COMPL);
  wire        last_phase   = (phase_q == 2'd3);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q           <= 1'b0;
      phase_q          <= 2'd0;
      ir_q             <= 14'h0000;
      result_q         <= 8'h00;
      acc_q            <= `CCE_RST_ACC;
      zero_q           <= 1'b0;
      timeout_flag_q   <= 1'b1;
      powerdown_flag_q <= 1'b1;
      file_we_q        <= 1'b0;
      file_addr_q      <= 7'h00;
      file_wdata_q     <= 8'h00;
      wdog_clear_q     <= 1'b0;
      illegal_q        <= 1'b0;
    end else begin
      file_we_q    <= 1'b0;
      wdog_clear_q <= 1'b0;
      if (!busy_q) begin
        if (start) begin
          // q1: decode
          busy_q  <= 1'b1;
          phase_q <= 2'd1;
          ir_q    <= instr;
        end
      end else begin
        phase_q <= phase_q + 2'd1;
        if (phase_q == 2'd1) begin
          // q2: read the addressed file register
          file_addr_q <= ir_q[6:0];
        end
        if (phase_q == 2'd2) begin
          result_q <= ~file_rdata;
        end
        if (last_phase) begin
          // q4: all results land here, one cycle total
          busy_q    <= 1'b0;
          illegal_q <= !(is_acc_clear || is_wdog || is_compl);
          if (is_acc_clear) begin
            acc_q  <= 8'h00;
            zero_q <= 1'b1;
          end
          if (is_wdog) begin
            // counter and prescaler count cleared together; assignment untouched
            wdog_clear_q     <= 1'b1;
            timeout_flag_q   <= 1'b1;
            powerdown_flag_q <= 1'b1;
          end
          if (is_compl) begin
            zero_q <= (result_q == 8'h00);
            if (ir_q[`CCE_DEST_BIT]) begin
              file_we_q    <= 1'b1;
              file_wdata_q <= result_q;
            end else begin
              acc_q <= result_q;
            end
          end
        end
      end
    end
  end
endmodule // cce_exec_unit

// ---- rtl/cce_top.v ----
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "cce_defines.vh"
// Functional notes
// - the accumulator-clear opcode loads zero into the accumulator and sets the zero flag.
// - the watchdog-restart opcode returns the watchdog counter to zero.
// - the same opcode clears the prescaler count in the same cycle as the counter.
// - the watchdog-restart opcode sets both the timeout flag and the powerdown flag.
// - the prescaler assignment and division ratio are left untouched by the restart.
// - the complement opcode inverts the addressed file register and sets zero from it.
// - with destination bit 0 the inverted value goes to the accumulator only.
// - with destination bit 1 the inverted value is written back to the file register.
module cce_top #(
  parameter PRESCALE_W = 8
) (
  input  wire        core_clk,
  input  wire        resetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        file_we,
  output wire [6:0]  file_addr,
  output wire [7:0]  file_wdata,
  output wire        timeout_flag,
  output wire        powerdown_flag,
  output wire        watchdog_expired
);
  // =====================================================
  // software-visible state
  reg  [13:0] instr_q;
  reg  [7:0]  frdata_q;
  reg  [7:0]  wdog_limit_q;
  reg  [7:0]  fwdata_last_q;
  reg  [6:0]  faddr_last_q;
  reg         go_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         aw_have_q;
  reg         w_have_q;

  wire        busy;
  wire [7:0]  acc;
  wire        zero;
  wire        illegal;
  wire        wdog_clear;
  // =====================================================
  // execution unit
  cce_exec_unit u_exec (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .start            (go_q),
    .instr            (instr_q),
    .file_rdata       (frdata_q),
    .busy_q           (busy),
    .acc_q            (acc),
    .zero_q           (zero),
    .timeout_flag_q   (timeout_flag),
    .powerdown_flag_q (powerdown_flag),
    .file_we_q        (file_we),
    .file_addr_q      (file_addr),
    .file_wdata_q     (file_wdata),
    .wdog_clear_q     (wdog_clear),
    .illegal_q        (illegal)
  );
  // =====================================================
  // watchdog counter with prescaler; the prescaler ratio is fixed by
  // PRESCALE_W and no instruction here can change it
  reg  [PRESCALE_W-1:0] presc_q;
  reg  [7:0]            wdog_q;
  reg                   expired_q;
  assign watchdog_expired = expired_q;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presc_q   <= {PRESCALE_W{1'b0}};
      wdog_q    <= 8'h00;
      expired_q <= 1'b0;
    end else if (wdog_clear) begin
      presc_q   <= {PRESCALE_W{1'b0}};
      wdog_q    <= 8'h00;
      expired_q <= 1'b0;
    end else begin
      presc_q <= presc_q + {{(PRESCALE_W-1){1'b0}}, 1'b1};
      if (presc_q == {PRESCALE_W{1'b1}}) begin
        if (wdog_q == wdog_limit_q) begin
          expired_q <= 1'b1;
        end else begin
          wdog_q <= wdog_q + 8'h01;
        end
      end
    end
  end
  // =====================================================
  // axi4-lite write channel; address and data taken in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  wire   do_write      = aw_have_q && w_have_q && !s_axi_bvalid;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCE_AXI_OKAY;
      instr_q       <= 14'h0000;
      frdata_q      <= 8'h00;
      wdog_limit_q  <= `CCE_RST_WDOG_LIMIT;
      go_q          <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CCE_AXI_OKAY;
        case (aw_addr_q)
          `CCE_ADDR_CTRL: begin
            // a start while busy is ignored; the running cycle completes
            if (w_strb_q[0] && w_data_q[`CCE_CTRL_GO] && !busy) begin
              go_q <= 1'b1;
            end
          end
          `CCE_ADDR_INSTR: begin
            if (w_strb_q[0]) instr_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1]) instr_q[13:8] <= w_data_q[13:8];
          end
          `CCE_ADDR_FRDATA: begin
            if (w_strb_q[0]) frdata_q <= w_data_q[7:0];
          end
          `CCE_ADDR_WDOG: begin
            if (w_strb_q[0]) wdog_limit_q <= w_data_q[7:0];
          end
          `CCE_ADDR_FADDR, `CCE_ADDR_ACC, `CCE_ADDR_STATUS, `CCE_ADDR_FWDATA: begin
            s_axi_bresp <= `CCE_AXI_OKAY;
          end
          default: begin
            s_axi_bresp <= `CCE_AXI_SLVERR;
          end
        endcase
      end
    end
  end
  // =====================================================
  // capture of the last file write-back for software inspection
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fwdata_last_q <= 8'h00;
      faddr_last_q  <= 7'h00;
    end else if (file_we) begin
      fwdata_last_q <= file_wdata;
      faddr_last_q  <= file_addr;
    end
  end
  // =====================================================
  // axi4-lite read channel
  reg  [31:0] rd_mux;
  reg         rd_err;
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `CCE_ADDR_CTRL:   rd_mux = 32'h00000000;
      `CCE_ADDR_INSTR:  rd_mux = {18'h00000, instr_q};
      `CCE_ADDR_FADDR:  rd_mux = {25'h0000000, faddr_last_q};
      `CCE_ADDR_FRDATA: rd_mux = {24'h000000, frdata_q};
      `CCE_ADDR_ACC:    rd_mux = {24'h000000, acc};
      `CCE_ADDR_STATUS: begin
        rd_mux[`CCE_ST_BUSY]      = busy;
        rd_mux[`CCE_ST_ZERO]      = zero;
        rd_mux[`CCE_ST_TIMEOUT]   = timeout_flag;
        rd_mux[`CCE_ST_POWERDOWN] = powerdown_flag;
        rd_mux[`CCE_ST_FWRITE]    = file_we;
        rd_mux[`CCE_ST_ILLEGAL]   = illegal;
      end
      `CCE_ADDR_FWDATA: rd_mux = {24'h000000, fwdata_last_q};
      `CCE_ADDR_WDOG:   rd_mux = {7'h00, expired_q, wdog_q, 8'h00, wdog_limit_q};
      default:          rd_err = 1'b1;
    endcase
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `CCE_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_err ? `CCE_AXI_SLVERR : `CCE_AXI_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cce_top

// ---- test/cce_chk.sv ----
`timescale 1ns/1ps
// ==========
// port checks
module cce_chk (
  input wire        core_clk,
  input wire        resetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        file_we,
  input wire [6:0]  file_addr,
  input wire [7:0]  file_wdata,
  input wire        timeout_flag,
  input wire        powerdown_flag,
  input wire        watchdog_expired
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  chk_we_pulse: assert property (file_we |=> !file_we)
    else $error("file write strobe too long");
  chk_we_addr: assert property (file_we |-> $stable(file_addr))
    else $error("file address moved at write");
  chk_we_data: assert property (file_we |=> $stable(file_wdata))
    else $error("write data not held");
  chk_to_kept: assert property (!$fell(timeout_flag))
    else $error("timeout flag dropped");
  chk_pd_kept: assert property (!$fell(powerdown_flag))
    else $error("powerdown flag dropped");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  cover property (file_we);
  cover property ($fell(watchdog_expired));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule // cce_chk
bind cce_top cce_chk cce_chk_inst (.core_clk, .resetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .file_we, .file_addr, .file_wdata, .timeout_flag,
  .powerdown_flag, .watchdog_expired);

// ---- test/cce_filemem.sv ----
`timescale 1ns/1ps
// ==========
// file register bank behind the write port
module cce_filemem (
  input wire       core_clk,
  input wire       file_we,
  input wire [6:0] file_addr,
  input wire [7:0] file_wdata
);
  logic [7:0] mem [0:127];
  int         wr_count = 0;
  always @(posedge core_clk) begin
    if (file_we) begin
      mem[file_addr] <= file_wdata;
      wr_count <= wr_count + 1;
    end
  end
endmodule // cce_filemem

// ---- test/test_clear_complement_exec.sv ----
`timescale 1ns/1ps
`include "cce_defines.vh"
module test_clear_complement_exec;
  logic        core_clk, resetn, awv, wv, br, arv, rr;
  logic [7:0]  awa, ara;
  logic [31:0] wd, v;
  logic [1:0]  r;
  wire         awr, wr_rdy, bv, arr, rv, fwe, tof, pdf, wexp;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [6:0]   fad;
  wire [7:0]   fwd;
  int          err_count = 0;
  int          tests_run = 0;
  cce_top #(.PRESCALE_W(8)) cce_top_inst (.core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .file_we(fwe), .file_addr(fad), .file_wdata(fwd),
    .timeout_flag(tof), .powerdown_flag(pdf), .watchdog_expired(wexp));
  cce_filemem cce_filemem_inst (.core_clk(core_clk), .file_we(fwe), .file_addr(fad),
    .file_wdata(fwd));
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  // ==========
  // reporting
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tmo;
    err_count++;
    $display("BAD bus wait ran out");
    finish_test();
  endtask
  // ==========
  // bus master, entered just after a rising edge
  // a lag above 0 keeps bready or rready low for lag+1 edges, so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int lag = 0);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= (lag == 0);
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (awr) awv <= 1'h0;
      if (wr_rdy) wv <= 1'h0;
      if (bv && br) break;
      if (n >= lag) br <= 1'h1;
    end
    if (n == 40) tmo();
    r = bresp;
    br <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input int lag = 0);
    int n;
    ara <= a;
    arv <= 1'h1;
    rr <= (lag == 0);
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (arr) arv <= 1'h0;
      if (rv && rr) break;
      if (n >= lag) rr <= 1'h1;
    end
    if (n == 40) tmo();
    v = rdata;
    r = rresp;
    rr <= 1'h0;
    @(posedge core_clk);
  endtask
  // completion is fixed at four phases after go, so a fixed wait is allowed
  task automatic exec(input logic [13:0] i, input logic [7:0] f);
    wr(`CCE_ADDR_INSTR, {18'h0, i});
    wr(`CCE_ADDR_FRDATA, {24'h0, f});
    wr(`CCE_ADDR_CTRL, 32'h1);
    repeat (8) @(posedge core_clk);
    rd(`CCE_ADDR_STATUS);
    chk("busy", v[`CCE_ST_BUSY], 32'h0);
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    rd(`CCE_ADDR_STATUS);
    chk("st_rst", v & 32'h2d, 32'h0c);
    rd(`CCE_ADDR_WDOG, 3);
    chk("limit", v[7:0], 32'hff);
    rd(8'h40);
    chk("rd_unmap", r, `CCE_AXI_SLVERR);
    wr(8'h44, 32'h0, 3);
    chk("wr_unmap", r, `CCE_AXI_SLVERR);
  endtask
  task automatic t_compl_file;
    int n0;
    n0 = cce_filemem_inst.wr_count;
    exec(14'h09ff, 8'haa);
    chk("mem7f", cce_filemem_inst.mem[7'h7f], 32'h55);
    chk("wrs", cce_filemem_inst.wr_count - n0, 32'h1);
    rd(`CCE_ADDR_FADDR);
    chk("faddr", v, 32'h7f);
    exec(14'h0985, 8'hff);
    chk("mem05", cce_filemem_inst.mem[7'h05], 32'h0);
    rd(`CCE_ADDR_STATUS);
    chk("zero_1", v[`CCE_ST_ZERO], 32'h1);
  endtask
  task automatic t_compl_acc;
    int n0;
    n0 = cce_filemem_inst.wr_count;
    exec(14'h0913, 8'h13);
    chk("no_wr", cce_filemem_inst.wr_count - n0, 32'h0);
    rd(`CCE_ADDR_ACC);
    chk("acc_c", v, 32'hec);
    rd(`CCE_ADDR_STATUS);
    chk("zero_0", v[`CCE_ST_ZERO], 32'h0);
  endtask
  // an opcode outside the three must leave accumulator and file bank alone
  task automatic t_illegal;
    int n0;
    n0 = cce_filemem_inst.wr_count;
    exec(14'h3fff, 8'h00);
    chk("ill_wr", cce_filemem_inst.wr_count - n0, 32'h0);
    rd(`CCE_ADDR_STATUS);
    chk("illegal", v[`CCE_ST_ILLEGAL], 32'h1);
    rd(`CCE_ADDR_ACC);
    chk("acc_keep", v, 32'hec);
  endtask
  task automatic t_acc_clear;
    exec(14'h015a, 8'h77);
    rd(`CCE_ADDR_ACC);
    chk("acc_0", v, 32'h0);
    rd(`CCE_ADDR_STATUS);
    chk("zero_c", v[`CCE_ST_ZERO], 32'h1);
    chk("legal", v[`CCE_ST_ILLEGAL], 32'h0);
  endtask
  // prescaler of 256 cycles: counter must stay 0 to ~200 and be 1 by ~320
  task automatic t_wdog;
    int n;
    wr(`CCE_ADDR_WDOG, 32'h2);
    for (n = 0; n < 20 && wexp !== 1'h1; n++) repeat (100) @(posedge core_clk);
    chk("expired", wexp, 32'h1);
    exec(`CCE_OP_WDOG, 8'h00);
    rd(`CCE_ADDR_WDOG);
    chk("cnt_clr", v[24:16], 32'h0);
    chk("flags", {tof, pdf}, 32'h3);
    repeat (180) @(posedge core_clk);
    rd(`CCE_ADDR_WDOG);
    chk("cnt_pre", v[23:16], 32'h0);
    repeat (120) @(posedge core_clk);
    rd(`CCE_ADDR_WDOG);
    chk("cnt_ratio", v[23:16], 32'h1);
  endtask
  initial begin
    resetn = 0;
    awv = 0;
    wv = 0;
    br = 0;
    arv = 0;
    rr = 0;
    awa = 0;
    ara = 0;
    wd = 0;
    repeat (4) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    t_reset();
    t_compl_file();
    t_compl_acc();
    t_illegal();
    t_acc_clear();
    t_wdog();
    finish_test();
  end
endmodule // test_clear_complement_exec
